// [home_search_pkg.sv]
// Package of constants for the home search sequencer
package home_search_pkg;
	// -----------------------------------------------------------------
	// Clock and commands
	// -----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 40_000_000;       // System clock rate
	localparam logic [7:0]  CMD_STEP_CONFIG   = 8'h23;          // Load step configuration
	localparam logic [7:0]  CMD_FINISH_CONFIG = 8'h24;          // Load finish configuration
	localparam logic [15:0] CONFIG_RESET      = 16'h0000;       // Both parameters reset value
	// -----------------------------------------------------------------
	// Step configuration fields
	// -----------------------------------------------------------------
	localparam int FAST_EN = 0;
	localparam int FAST_DIR = 1;
	localparam int FAST_SIG_LO = 2;
	localparam int FAST_SIG_HI = 3;
	localparam int SLOW_EN = 4;
	localparam int SLOW_DIR = 5;
	localparam int SLOW_SIG = 6;
	localparam int SLOW_DCC = 7;
	localparam int SLOW_RC = 8;
	localparam int SLOW_LC = 9;
	localparam int IDX_EN = 10;
	localparam int IDX_DIR = 11;
	localparam int IDX_DCC = 12;
	localparam int IDX_RC = 13;
	localparam int IDX_LC = 14;
	localparam int OFS_EN = 15;
	// -----------------------------------------------------------------
	// Finish configuration fields
	// -----------------------------------------------------------------
	localparam int AND_STOP = 0;
	localparam int END_RC = 1;
	localparam int END_LC = 2;
	localparam int DCC_POL = 3;
	localparam int DCC_W_LSB = 4;
	localparam int TMR_EN = 7;
	localparam int TMR_LSB = 8;
	// -----------------------------------------------------------------
	// Times in microseconds, per 3-bit code
	// -----------------------------------------------------------------
	localparam int unsigned DCC_US [8] = '{10, 20, 100, 200, 1000, 2000, 10000, 20000};
	localparam int unsigned TMR_US [8] = '{1000, 2000, 10000, 20000, 100000, 200000,
		500000, 1000000};
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;    // Cycles per microsecond
	localparam int          CNT_W      = 27;                    // Fits 1 s at 40 MHz
	// Step states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_FAST = 3'b001,
		ST_SLOW = 3'b010,
		ST_IDX  = 3'b011,
		ST_OFS  = 3'b100,
		ST_WAIT = 3'b101,
		ST_END  = 3'b110
	} step_state_t;
endpackage

// [pulse_timer.sv]
// Loadable down counter used for the clear pulse and the step wait
`timescale 1ns/1ps
module pulse_timer
	import home_search_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             load_i,     // Start counting
	input  wire logic [CNT_W-1:0] count_i,    // Cycles to run
	output logic                  busy_o      // High while counting
);
	logic [CNT_W-1:0] cnt_q;                  // Remaining cycles
	logic [CNT_W-1:0] cnt_d;
	// -----------------------------------------------------------------
	// Next count
	// -----------------------------------------------------------------
	always_comb
	begin
		cnt_d = cnt_q;
		if (load_i)
			cnt_d = count_i;
		else if (cnt_q != '0)
			cnt_d = cnt_q - 1'b1;
	end
	// Register
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
	assign busy_o = (cnt_q != '0);
endmodule // pulse_timer

// [home_search_sequencer.sv]
// Automatic home search sequencer for one axis
// What this block does
// - Command 23h loads step configuration word
// - Command 24h loads finish configuration word
// - Fast step runs only when enabled
// - Fast step direction bit: 0 plus
// - Fast step input: stop a, b, limit
// - Slow step enable, direction, input select
// - Slow detect: clear pulse, real, logic clears
// - Index step enable and direction
// - Index detect: clear pulse, real, logic clears
// - Offset drive runs only when enabled
// - And-stop: index edge while stop b active
// - And-stop only when slow uses stop b
// - End clears real and logic counters
// - Clear pulse polarity from finish bit 3
// - Clear pulse width from 3-bit code
// - Step wait only when timer enabled
// - Step wait interval from 3-bit code
// - Both configuration words reset to zero
// - Input active levels from polarity register
`timescale 1ns/1ps
module home_search_sequencer
	import home_search_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        cmd_valid_i,          // Command strobe, one cycle
	input  wire logic [7:0]  cmd_code_i,           // Command code
	input  wire logic [15:0] write_data_low_i,     // Write data register
	input  wire logic [4:0]  input_polarity_reg_i, // 1 = active high, per input
	input  wire logic        start_i,              // Begin a home search
	input  wire logic        stop_input_a_i,       // Raw pin levels
	input  wire logic        stop_input_b_i,
	input  wire logic        index_stop_input_i,
	input  wire logic        limit_plus_i,
	input  wire logic        limit_minus_i,
	input  wire logic        offset_done_i,        // Motion core finished offset drive
	output logic             busy_o,               // Search in progress
	output logic [1:0]       drive_mode_o,         // 0 none, 1 fast, 2 slow, 3 offset
	output logic             drive_minus_o,        // Direction, 1 = minus
	output logic             real_clear_o,         // One-cycle counter clear
	output logic             logic_clear_o,        // One-cycle counter clear
	output logic             dev_clear_output_o,   // Deviation counter clear pin
	output logic             config_error_o        // Invalid input select seen
);
	import home_search_pkg::*;
	// -----------------------------------------------------------------
	// Configuration registers
	// -----------------------------------------------------------------
	logic [15:0] home_step_config_q, home_step_config_d;     // Step parameters
	logic [15:0] home_finish_config_q, home_finish_config_d; // Finish parameters
	// Load on command; reserved upper bits kept as written, host keeps them zero
	always_comb
	begin
		home_step_config_d   = home_step_config_q;
		home_finish_config_d = home_finish_config_q;
		if (cmd_valid_i && cmd_code_i == CMD_STEP_CONFIG)
			home_step_config_d = write_data_low_i;
		if (cmd_valid_i && cmd_code_i == CMD_FINISH_CONFIG)
			home_finish_config_d = write_data_low_i;
	end
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			home_step_config_q   <= CONFIG_RESET;
			home_finish_config_q <= CONFIG_RESET;
		end
		else
		begin
			home_step_config_q   <= home_step_config_d;
			home_finish_config_q <= home_finish_config_d;
		end
	end
	// -----------------------------------------------------------------
	// Field aliases
	// -----------------------------------------------------------------
	logic [15:0] sc, fc;
	assign sc = home_step_config_q;
	assign fc = home_finish_config_q;
	logic [1:0] fast_sel;
	assign fast_sel = {sc[FAST_SIG_HI], sc[FAST_SIG_LO]};
	// -----------------------------------------------------------------
	// Input levels, polarity applied
	// -----------------------------------------------------------------
	// Polarity bit set means the pin is active high; XNOR gives active
	logic act_a, act_b, act_idx, act_lp, act_lm;
	assign act_a   = ~(stop_input_a_i     ^ input_polarity_reg_i[0]);
	assign act_b   = ~(stop_input_b_i     ^ input_polarity_reg_i[1]);
	assign act_idx = ~(index_stop_input_i ^ input_polarity_reg_i[2]);
	assign act_lp  = ~(limit_plus_i       ^ input_polarity_reg_i[3]);
	assign act_lm  = ~(limit_minus_i      ^ input_polarity_reg_i[4]);
	logic idx_prev_q;                                          // For index edge
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			idx_prev_q <= 1'b0;
		else
			idx_prev_q <= act_idx;
	end
	// -----------------------------------------------------------------
	// Detection per step
	// -----------------------------------------------------------------
	logic fast_hit, slow_hit, idx_hit, and_ok;
	always_comb
	begin
		case (fast_sel)
			2'b00:   fast_hit = act_a;
			2'b01:   fast_hit = act_b;
			2'b10:   fast_hit = sc[FAST_DIR] ? act_lm : act_lp;
			default: fast_hit = 1'b0;                                 // Invalid code
		endcase
	end
	assign slow_hit = sc[SLOW_SIG] ? (sc[SLOW_DIR] ? act_lm : act_lp) : act_b;
	// And-stop counts only with stop b as the slow input
	assign and_ok  = fc[AND_STOP] && !sc[SLOW_SIG];
	assign idx_hit = and_ok ? (act_idx && !idx_prev_q && act_b)
	                        : act_idx;
	// -----------------------------------------------------------------
	// Timers
	// -----------------------------------------------------------------
	logic             dcc_load, tmr_load, dcc_busy, tmr_busy;
	logic [CNT_W-1:0] dcc_cycles, tmr_cycles;
	// One less than the width, since the load cycle is the first active cycle
	assign dcc_cycles = CNT_W'(DCC_US[fc[DCC_W_LSB +: 3]] * CYC_PER_US - 1);
	assign tmr_cycles = CNT_W'(TMR_US[fc[TMR_LSB +: 3]] * CYC_PER_US);
	pulse_timer dcc_timer
	(
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.load_i  (dcc_load),
		.count_i (dcc_cycles),
		.busy_o  (dcc_busy)
	);
	pulse_timer step_timer
	(
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.load_i  (tmr_load),
		.count_i (tmr_cycles),
		.busy_o  (tmr_busy)
	);
	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	step_state_t state_q, state_d;            // Current step
	step_state_t after_q, after_d;            // Step that follows a wait
	logic        err_q, err_d;                // Sticky invalid-select flag
	logic        end_real_clear_d, end_logic_clear_d;              // Counter clear pulses
	logic        end_real_clear_q, end_logic_clear_q;
	// Pick the next enabled step at or after a given one
	function automatic step_state_t next_from(input step_state_t s, input logic [15:0] c);
		step_state_t r;
		r = ST_END;
		case (s)
			ST_FAST: r = c[FAST_EN] ? ST_FAST : c[SLOW_EN] ? ST_SLOW :
			             c[IDX_EN] ? ST_IDX : c[OFS_EN] ? ST_OFS : ST_END;
			ST_SLOW: r = c[SLOW_EN] ? ST_SLOW : c[IDX_EN] ? ST_IDX :
			             c[OFS_EN] ? ST_OFS : ST_END;
			ST_IDX:  r = c[IDX_EN] ? ST_IDX : c[OFS_EN] ? ST_OFS : ST_END;
			ST_OFS:  r = c[OFS_EN] ? ST_OFS : ST_END;
			default: r = ST_END;
		endcase
		return r;
	endfunction
	// Next state and one-cycle actions
	always_comb
	begin
		step_state_t nxt;
		nxt      = ST_END;
		state_d  = state_q;
		after_d  = after_q;
		err_d    = err_q;
		end_real_clear_d   = 1'b0;
		end_logic_clear_d   = 1'b0;
		dcc_load = 1'b0;
		tmr_load = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (start_i)
				begin
					err_d   = 1'b0;
					state_d = next_from(ST_FAST, sc);
				end
			end
			ST_FAST:
			begin
				if (fast_sel == 2'b11)
				begin
					err_d   = 1'b1;                                   // Abort on invalid code
					state_d = ST_IDLE;
				end
				else if (fast_hit)
					nxt = next_from(ST_SLOW, sc);
			end
			ST_SLOW:
			begin
				if (slow_hit)
				begin
					dcc_load = sc[SLOW_DCC];
					end_real_clear_d   = sc[SLOW_RC];
					end_logic_clear_d   = sc[SLOW_LC];
					nxt      = next_from(ST_IDX, sc);
				end
			end
			ST_IDX:
			begin
				if (idx_hit)
				begin
					dcc_load = sc[IDX_DCC];
					end_real_clear_d   = sc[IDX_RC];
					end_logic_clear_d   = sc[IDX_LC];
					nxt      = next_from(ST_OFS, sc);
				end
			end
			ST_OFS:
			begin
				if (offset_done_i)
					nxt = ST_END;
			end
			ST_WAIT:
			begin
				if (!tmr_busy)
					state_d = after_q;
			end
			ST_END:
			begin
				end_real_clear_d  = fc[END_RC];
				end_logic_clear_d  = fc[END_LC];
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		// A completed step goes through the wait when enabled
		if (nxt != ST_END || ((state_q == ST_FAST && fast_hit && fast_sel != 2'b11)
			|| (state_q == ST_SLOW && slow_hit) || (state_q == ST_IDX && idx_hit)
			|| (state_q == ST_OFS && offset_done_i)))
		begin
			if (fc[TMR_EN])
			begin
				tmr_load = 1'b1;
				after_d  = nxt;
				state_d  = ST_WAIT;
			end
			else
				state_d = nxt;
		end
	end
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q <= ST_IDLE;
			after_q <= ST_IDLE;
			err_q   <= 1'b0;
			end_real_clear_q  <= 1'b0;
			end_logic_clear_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			after_q <= after_d;
			err_q   <= err_d;
			end_real_clear_q  <= end_real_clear_d;
			end_logic_clear_q  <= end_logic_clear_d;
		end
	end
	// -----------------------------------------------------------------
	// Drive outputs, registered
	// -----------------------------------------------------------------
	logic [1:0] mode_q, mode_d;
	logic       dir_q, dir_d, dcc_q, dcc_d;
	always_comb
	begin
		mode_d = 2'd0;
		dir_d  = 1'b0;
		case (state_d)
			ST_FAST: begin mode_d = 2'd1; dir_d = sc[FAST_DIR]; end
			ST_SLOW: begin mode_d = 2'd2; dir_d = sc[SLOW_DIR]; end
			ST_IDX:  begin mode_d = 2'd2; dir_d = sc[IDX_DIR];  end
			ST_OFS:  begin mode_d = 2'd3; dir_d = 1'b0;         end
			default: begin mode_d = 2'd0; dir_d = 1'b0;         end
		endcase
		// Idle at inactive level; active in the load cycle and while the width timer runs
		dcc_d = (dcc_load | dcc_busy) ^ fc[DCC_POL];
	end
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			mode_q <= 2'd0;
			dir_q  <= 1'b0;
			dcc_q  <= 1'b0;
		end
		else
		begin
			mode_q <= mode_d;
			dir_q  <= dir_d;
			dcc_q  <= dcc_d;
		end
	end
	assign busy_o             = (state_q != ST_IDLE);
	assign drive_mode_o       = mode_q;
	assign drive_minus_o      = dir_q;
	assign real_clear_o       = end_real_clear_q;
	assign logic_clear_o      = end_logic_clear_q;
	assign dev_clear_output_o = dcc_q;
	assign config_error_o     = err_q;
endmodule // home_search_sequencer

// [home_search_sva.sv]
// Port-level checker for the home search sequencer
`timescale 1ns/1ps
module home_search_sva
	import home_search_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        cmd_valid_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic [15:0] write_data_low_i,
	input wire logic [4:0]  input_polarity_reg_i,
	input wire logic        start_i,
	input wire logic        stop_input_a_i,
	input wire logic        stop_input_b_i,
	input wire logic        index_stop_input_i,
	input wire logic        limit_plus_i,
	input wire logic        limit_minus_i,
	input wire logic        offset_done_i,
	input wire logic        busy_o,
	input wire logic [1:0]  drive_mode_o,
	input wire logic        drive_minus_o,
	input wire logic        real_clear_o,
	input wire logic        logic_clear_o,
	input wire logic        dev_clear_output_o,
	input wire logic        config_error_o
);
	// -----------------------------------------------------------------
	// Shadow copies of the two words and a pulse length counter
	// -----------------------------------------------------------------
	logic [15:0] c1_q, c1_d, c2_q, c2_d;  // Shadow configuration words
	logic [19:0] cnt_q, cnt_d;            // Cycles the clear pin has been active
	logic [19:0] w;                       // Expected active width
	logic        act, hit;                // Clear pin active, fast input seen
	// Next values; the shadow decodes the command strobe at the ports itself
	always_comb
	begin
		c1_d = (cmd_valid_i && cmd_code_i == CMD_STEP_CONFIG) ? write_data_low_i : c1_q;
		c2_d = (cmd_valid_i && cmd_code_i == CMD_FINISH_CONFIG) ? write_data_low_i : c2_q;
		act = dev_clear_output_o != c2_q[DCC_POL];
		cnt_d = act ? cnt_q + 20'h00001 : 20'h00000;
		w = 20'(DCC_US[c2_q[6:4]] * CYC_PER_US);
		case (c1_q[3:2])
			2'b00:   hit = stop_input_a_i == input_polarity_reg_i[0];
			2'b01:   hit = stop_input_b_i == input_polarity_reg_i[1];
			default: hit = drive_minus_o ? limit_minus_i == input_polarity_reg_i[4]
				: limit_plus_i == input_polarity_reg_i[3];
		endcase
	end
	// Registers only
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			c1_q <= CONFIG_RESET;
			c2_q <= CONFIG_RESET;
			cnt_q <= 20'h00000;
		end
		else
		begin
			c1_q <= c1_d;
			c2_q <= c2_d;
			cnt_q <= cnt_d;
		end
	end
	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	AST_FAST_RUN: assert property ($rose(busy_o) && c1_q[FAST_EN] && c1_q[3:2] != 2'b11 |->
		drive_mode_o == 2'd1 && drive_minus_o == c1_q[FAST_DIR]) else $error("fast step wrong");
	AST_FAST_SKIP: assert property ($rose(busy_o) && !c1_q[FAST_EN] |-> drive_mode_o != 2'd1)
		else $error("disabled fast step ran");
	AST_FAST_HIT: assert property (drive_mode_o == 2'd1 && c1_q[3:2] != 2'b11 && hit |->
		##[1:3] drive_mode_o != 2'd1) else $error("fast step missed its input");
	AST_BAD_SEL: assert property (start_i && !busy_o && c1_q[FAST_EN] && c1_q[3:2] == 2'b11 |->
		##[1:3] (config_error_o && !busy_o)) else $error("invalid select not refused");
	AST_OFS_GATE: assert property (drive_mode_o == 2'd3 |-> c1_q[OFS_EN])
		else $error("offset drive while disabled");
	AST_IDLE_MODE: assert property (!busy_o |-> drive_mode_o == 2'd0)
		else $error("drive while idle");
	AST_DCC_IDLE: assert property (!busy_o && cnt_q == 20'h0 && $past(c2_q[DCC_POL], 2) ==
		c2_q[DCC_POL] |-> !act) else $error("clear pin not at rest");
	AST_DCC_WIDTH: assert property ($fell(act) && $past(c2_q[DCC_POL], 2) == c2_q[DCC_POL] |->
		cnt_q == w) else $error("clear pulse width wrong");
	AST_END_CLR: assert property ($fell(busy_o) && !config_error_o |->
		(!c2_q[END_RC] || real_clear_o || $past(real_clear_o) || $past(real_clear_o, 2)) &&
		(!c2_q[END_LC] || logic_clear_o || $past(logic_clear_o) || $past(logic_clear_o, 2)))
		else $error("end clear missing");
	COV_PULSE: cover property ($fell(act));
	COV_OFFSET: cover property (drive_mode_o == 2'd3);
	COV_ERROR: cover property ($rose(config_error_o));
endmodule // home_search_sva

bind home_search_sequencer home_search_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
	.cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .write_data_low_i(write_data_low_i),
	.input_polarity_reg_i(input_polarity_reg_i), .start_i(start_i),
	.stop_input_a_i(stop_input_a_i), .stop_input_b_i(stop_input_b_i),
	.index_stop_input_i(index_stop_input_i), .limit_plus_i(limit_plus_i),
	.limit_minus_i(limit_minus_i), .offset_done_i(offset_done_i), .busy_o(busy_o),
	.drive_mode_o(drive_mode_o), .drive_minus_o(drive_minus_o), .real_clear_o(real_clear_o),
	.logic_clear_o(logic_clear_o), .dev_clear_output_o(dev_clear_output_o),
	.config_error_o(config_error_o));

// [motion_sensor_model.sv]
// Axis model: moves on drive requests and reports sensor levels
`timescale 1ns/1ps
module motion_sensor_model
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [1:0] drive_mode_i,   // 0 none, else moving
	input  wire logic       drive_minus_i,  // 1 = minus
	output logic            stop_a_o,
	output logic            stop_b_o,
	output logic            index_o,
	output logic            lim_p_o,
	output logic            lim_m_o,
	output logic            offset_done_o
);
	logic signed [15:0] pos_q;  // Axis position, one step per moving cycle
	logic [5:0]         ofs_q;  // Cycles spent in offset drive
	// Position only moves while a drive is requested, like a real axis
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pos_q <= 16'sh0000;
			ofs_q <= 6'h00;
		end
		else
		begin
			if (drive_mode_i != 2'd0)
				pos_q <= drive_minus_i ? pos_q - 16'sh0001 : pos_q + 16'sh0001;
			ofs_q <= drive_mode_i != 2'd3 ? 6'h00 : (ofs_q < 6'd20 ? ofs_q + 6'h01 : ofs_q);
		end
	end
	// Sensor levels are active high; the bench sets every polarity bit to match
	assign stop_a_o = pos_q >= 16'sd40 && pos_q <= 16'sd60;
	assign stop_b_o = pos_q >= -16'sd60 && pos_q <= -16'sd40;
	assign index_o = pos_q[3:0] == 4'h0;                          // One mark every 16 steps
	assign lim_p_o = pos_q >= 16'sd100;
	assign lim_m_o = pos_q <= -16'sd100;
	assign offset_done_o = ofs_q == 6'd20;
endmodule // motion_sensor_model

// [home_search_sequencer_tb.sv]
// Self-checking testbench for the home search sequencer
`timescale 1ns/1ps
module home_search_sequencer_tb;
	import home_search_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cmd_valid_i = 1'b0;
	logic [7:0]  cmd_code_i = 8'h00;
	logic [15:0] write_data_low_i = 16'h0000;
	logic        start_i = 1'b0;
	logic        sa, sb, ix, lp, lm, od;          // Sensor levels from the axis model
	logic        busy_o, drive_minus_o, real_clear_o, logic_clear_o, dcc, config_error_o;
	logic [1:0]  drive_mode_o;
	logic        exp_pol = 1'b0;                  // Rest level of the clear pin
	logic [2:0]  seq[$];                          // Nonzero mode and direction pairs, one per change
	int          fails = 0;
	int          samples_checked = 0;
	int          n_rc, n_lc, n_act, n_busy;
	always #12.5 clk_i = ~clk_i;
	home_search_sequencer u_dut (.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
		.cmd_code_i(cmd_code_i), .write_data_low_i(write_data_low_i),
		.input_polarity_reg_i(5'h1f), .start_i(start_i), .stop_input_a_i(sa),
		.stop_input_b_i(sb), .index_stop_input_i(ix), .limit_plus_i(lp), .limit_minus_i(lm),
		.offset_done_i(od), .busy_o(busy_o), .drive_mode_o(drive_mode_o),
		.drive_minus_o(drive_minus_o), .real_clear_o(real_clear_o),
		.logic_clear_o(logic_clear_o), .dev_clear_output_o(dcc), .config_error_o(config_error_o));
	motion_sensor_model u_axis (.clk_i(clk_i), .reset_i(reset_i), .drive_mode_i(drive_mode_o),
		.drive_minus_i(drive_minus_o), .stop_a_o(sa), .stop_b_o(sb), .index_o(ix), .lim_p_o(lp),
		.lim_m_o(lm), .offset_done_o(od));
	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	// Inputs always change 1 ns after the rising edge
	task cycle;
		@(posedge clk_i);
		#1;
	endtask
	task write_cfg(input logic [7:0] code, input logic [15:0] data);
		cycle();
		cmd_valid_i = 1'b1;
		cmd_code_i = code;
		write_data_low_i = data;
		cycle();
		cmd_valid_i = 1'b0;
	endtask
	// Start a search and log moves, clears and pulse length until all is quiet
	task run_search;
		int idle;
		logic [2:0] last;
		{n_rc, n_lc, n_act, n_busy, idle} = '0;
		last = 3'b000;
		seq.delete();
		cycle();
		start_i = 1'b1;
		cycle();
		start_i = 1'b0;
		for (int i = 0; i < 45000 && idle < 4; i++)
		begin
			if (drive_mode_o !== 2'd0 && {drive_mode_o, drive_minus_o} !== last)
				seq.push_back({drive_mode_o, drive_minus_o});
			last = {drive_mode_o, drive_minus_o};
			n_busy += busy_o;
			n_rc += real_clear_o;
			n_lc += logic_clear_o;
			n_act += (dcc !== exp_pol);
			idle = (busy_o === 1'b0 && dcc === exp_pol) ? idle + 1 : 0;
			cycle();
		end
		if (idle < 4)
		begin
			fails++;
			$display("MISMATCH %0t search never finished", $time);
			close_out();
		end
	endtask
	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task t_reset;
		check(busy_o, 1'b0, "busy after reset");
		check(dcc, 1'b0, "clear pin after reset");
		run_search();
		check(seq.size(), 0, "moves with zero words");
		check(n_rc + n_lc, 0, "clears with zero words");
		$display("test reset done");
	endtask
	// All four steps, ignored code last, negative clear pulse
	task t_full;
		write_cfg(CMD_STEP_CONFIG, 16'h85b1);
		write_cfg(CMD_FINISH_CONFIG, 16'h000e);
		// Unknown code last, so a wrong load would spoil the whole search
		write_cfg(8'h25, 16'hffff);
		exp_pol = 1'b1;
		cycle();
		check(dcc, 1'b1, "rest level negative");
		run_search();
		check(seq.size(), 4, "step count");
		check(seq[0], 3'b010, "fast plus");
		check(seq[1], 3'b101, "slow minus");
		check(seq[2], 3'b100, "index plus");
		check(seq[3], 3'b110, "offset");
		check(n_rc, 2, "real clears");
		check(n_lc, 1, "logic clears");
		check(n_act, DCC_US[0] * CYC_PER_US, "pulse width");
		$display("test full search done");
	endtask
	task t_err;
		write_cfg(CMD_STEP_CONFIG, 16'h000d);
		run_search();
		check(config_error_o, 1'b1, "invalid select");
		$display("test invalid select done");
	endtask
	// Limit search in minus, then the wait before the end
	task t_limit;
		write_cfg(CMD_STEP_CONFIG, 16'h000b);
		write_cfg(CMD_FINISH_CONFIG, 16'h0080);
		exp_pol = 1'b0;
		run_search();
		check(config_error_o, 1'b0, "error cleared by start");
		check(seq.size(), 1, "one step");
		check(seq[0], 3'b011, "fast minus to limit");
		check(n_busy >= TMR_US[0] * CYC_PER_US && n_busy <= TMR_US[0] * CYC_PER_US + 400,
			1'b1, "step wait");
		$display("test limit and wait done");
	endtask
	// Index step alone from the minus limit; and-stop needs stop b active
	task t_and;
		write_cfg(CMD_STEP_CONFIG, 16'h2400);
		write_cfg(CMD_FINISH_CONFIG, 16'h0001);
		run_search();
		check(n_rc, 1, "index real clear");
		check(n_busy >= 40 && n_busy <= 70, 1'b1, "and-stop mark");
		// Limit as slow input: and-stop is inert, the next mark ends the step
		write_cfg(CMD_STEP_CONFIG, 16'h2440);
		run_search();
		check(n_busy >= 10 && n_busy <= 25, 1'b1, "and-stop inert");
		$display("test and-stop done");
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		t_reset();
		t_full();
		t_err();
		t_limit();
		t_and();
		close_out();
	end
endmodule // home_search_sequencer_tb
